// file: shared/idpc_params.svh
`ifndef IDPC_PARAMS_SVH
`define IDPC_PARAMS_SVH

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define IDPC_CFG_IDX 18'h00000
`define IDPC_STAT_IDX 18'h00002
`define IDPC_MASK_IDX 18'h09400
`define IDPC_AW 20

// ----------------------------------------
// Reset values and writable bits
// ----------------------------------------
`define IDPC_CFG_RST 16'h0000
`define IDPC_MASK_RST 16'h0000
`define IDPC_CFG_WMASK 16'h03FF
`define IDPC_MASK_WMASK 16'h3FFF
`define IDPC_NDOM 9
`define IDPC_NUNIT 14

// ----------------------------------------
// Field positions, shared by control and status
// ----------------------------------------
`define IDPC_B_CORE 0
`define IDPC_B_MUNIT 1
`define IDPC_B_INSTR_CACHE 2
`define IDPC_B_UGROUP 3
`define IDPC_B_CLK 4
`define IDPC_B_EXT_MEM_IF 5
`define IDPC_B_IOPORT 6
`define IDPC_B_MASTER_PORT 7
`define IDPC_B_FPORT 8
`define IDPC_B_CLKX 9

// Bits that must all be set before the clock generator may idle
`define IDPC_PWRDN_SET 16'h03E7

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define IDPC_RESP_OKAY 2'h0
`define IDPC_RESP_SLVERR 2'h2

`endif

// file: shared/idpc_pkg.sv
package idpc_pkg;
	// Per-domain power sequence
	typedef enum logic [3:0] {
		DS_ACTIVE = 4'h1,
		DS_STOPPING = 4'h2,
		DS_STOPPED = 4'h4,
		DS_WAKING = 4'h8
	} idpc_dom_state_t;

	// Register selected by a bus address
	typedef enum logic [1:0] {
		RS_NONE = 2'h0,
		RS_CFG = 2'h1,
		RS_STAT = 2'h2,
		RS_MASK = 2'h3
	} idpc_sel_t;

	typedef logic [15:0] idpc_word_t;
endpackage : idpc_pkg

// file: core/idpc_dom.sv
`timescale 1ns/1ns
module idpc_dom
	import idpc_pkg::*;
(
	// Clock and synchronised reset
	input wire logic clk,
	input wire logic rst_n,
	// Handshake with the domain
	input wire logic idle_req,
	input wire logic stop_ack,
	// Status seen by software
	output logic idle_stat
);
	idpc_dom_state_t state;
	idpc_dom_state_t next_state;
	logic next_stat;

	// Status follows the domain's own answer, never the request alone
	always_comb begin
		next_state = state;
		case (state)
			DS_ACTIVE: begin
				if (idle_req) next_state = DS_STOPPING;
			end
			DS_STOPPING: begin
				if (!idle_req) next_state = DS_ACTIVE;
				else if (stop_ack) next_state = DS_STOPPED;
			end
			DS_STOPPED: begin
				if (!idle_req) next_state = DS_WAKING;
			end
			DS_WAKING: begin
				if (idle_req) next_state = DS_STOPPED;
				else if (!stop_ack) next_state = DS_ACTIVE;
			end
			default: next_state = DS_ACTIVE;
		endcase
		next_stat = (next_state == DS_STOPPED) || (next_state == DS_WAKING);
	end

	// State registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= DS_ACTIVE;
			idle_stat <= 1'b0;
		end else begin
			state <= next_state;
			idle_stat <= next_stat;
		end
	end

	a_stat_set_cause: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(idle_stat) |-> $past(stop_ack) && $past(idle_req))
		else $error("idle status set without stop answer");

	a_stat_clear_cause: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(idle_stat) |-> !$past(stop_ack) && !$past(idle_req))
		else $error("idle status cleared while domain still stopped");
endmodule : idpc_dom

// file: core/idpc_top.sv
`timescale 1ns/1ns
`include "idpc_params.svh"

// How it works
// - Idle instruction disables external memory interface when its control bit is set.
// - Idle instruction disables the I/O-space port when its control bit is set.
// - Clock generator stops only when both its idle and extended idle bits are set.
// - Clock idle set with extended bit clear raises a bus error at idle.
// - Clock idle with any power-down bit clear raises a bus error at idle.
// - Group bit clear: idle instruction makes every peripheral active.
// - Group bit set: idle disables exactly the peripherals marked in the mask.
// - Idle instruction disables the instruction cache when its control bit is set.
// - Idle instruction disables DMA and host port when the master bit is set.
// - Idle instruction disables the CPU when its control bit is set.
// - Status register sits at index 2, bits 15 to 9 read zero.
// - Status bits 8, 7, 6 show fetch, master and I/O-space port disabled.
// - Status bits 5 and 4 show memory interface and clock generator disabled.
// - Status bit 3 shows the peripheral group disabled.
// - Status bits 2, 1, 0 show cache, master units and CPU disabled.
// - Idle instruction disables the cache fetch port when its bit is set.
// - Idle instruction disables the master port when its bit is set.
// - Mask bits reset to zero and disable their peripheral under group idle.
// - Idle with group clear wakes all; with group set wakes unmasked ones.
module idpc_top
	import idpc_pkg::*;
(
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST_B,
	// AXI4-Lite write channels
	input wire logic [`IDPC_AW-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// AXI4-Lite read channels
	input wire logic [`IDPC_AW-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Idle instruction and wake event from the core
	input wire logic IDLE_EXEC,
	input wire logic WAKE_REQ,
	// Domain handshake
	output logic [`IDPC_NDOM-1:0] DOM_IDLE_REQ,
	input wire logic [`IDPC_NDOM-1:0] DOM_STOP_ACK,
	output logic [`IDPC_NUNIT-1:0] UNIT_IDLE,
	output logic BUS_ERR_IRQ
);
	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic [1:0] rst_sync;
	logic rst_n;

	// Assert at once, release two edges later
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) rst_sync <= 2'h0;
		else rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Registers sit one per word; low address bits are ignored
	function automatic idpc_sel_t reg_sel(input logic [`IDPC_AW-1:0] a);
		if (a[`IDPC_AW-1:2] == `IDPC_CFG_IDX) reg_sel = RS_CFG;
		else if (a[`IDPC_AW-1:2] == `IDPC_STAT_IDX) reg_sel = RS_STAT;
		else if (a[`IDPC_AW-1:2] == `IDPC_MASK_IDX) reg_sel = RS_MASK;
		else reg_sel = RS_NONE;
	endfunction : reg_sel

	// Byte-lane merge, reserved bits forced to zero
	function automatic idpc_word_t wr_merge(input idpc_word_t old, input logic [15:0] d,
		input logic [1:0] s, input idpc_word_t m);
		idpc_word_t r;
		r = old;
		if (s[0]) r[7:0] = d[7:0];
		if (s[1]) r[15:8] = d[15:8];
		wr_merge = r & m;
	endfunction : wr_merge

	// ----------------------------------------
	// Bus write path
	// ----------------------------------------
	logic aw_full, next_aw_full, w_full, next_w_full;
	logic [`IDPC_AW-1:0] aw_addr, next_aw_addr;
	logic [15:0] w_data, next_w_data;
	logic [1:0] w_strb, next_w_strb;
	logic next_awready, next_wready, next_bvalid;
	logic [1:0] next_bresp;
	logic wr_commit;
	idpc_sel_t wr_sel;

	// Address and data are held separately so either may come first
	always_comb begin
		next_aw_full = aw_full;
		next_aw_addr = aw_addr;
		next_w_full = w_full;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = S_AXI_BVALID;
		next_bresp = S_AXI_BRESP;
		wr_sel = reg_sel(aw_addr);
		wr_commit = aw_full && w_full && !S_AXI_BVALID;
		if (S_AXI_BVALID && S_AXI_BREADY) next_bvalid = 1'b0;
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			next_aw_full = 1'b1;
			next_aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			next_w_full = 1'b1;
			next_w_data = S_AXI_WDATA[15:0];
			next_w_strb = S_AXI_WSTRB[1:0];
		end
		if (wr_commit) begin
			next_aw_full = 1'b0;
			next_w_full = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = (wr_sel == RS_NONE) ? `IDPC_RESP_SLVERR : `IDPC_RESP_OKAY;
		end
		next_awready = !next_aw_full;
		next_wready = !next_w_full;
	end

	// Write path registers
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			aw_full <= 1'b0;
			aw_addr <= '0;
			w_full <= 1'b0;
			w_data <= 16'h0000;
			w_strb <= 2'h0;
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `IDPC_RESP_OKAY;
		end else begin
			aw_full <= next_aw_full;
			aw_addr <= next_aw_addr;
			w_full <= next_w_full;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			S_AXI_AWREADY <= next_awready;
			S_AXI_WREADY <= next_wready;
			S_AXI_BVALID <= next_bvalid;
			S_AXI_BRESP <= next_bresp;
		end
	end

	// ----------------------------------------
	// Idle control
	// ----------------------------------------
	idpc_word_t cfg, next_cfg, mask, next_mask;
	logic [`IDPC_NDOM-1:0] next_req, dom_stat;
	logic [`IDPC_NUNIT-1:0] next_unit;
	logic next_err, idle_bad;

	// Clock idle without the full power-down set is refused
	assign idle_bad = cfg[`IDPC_B_CLK] && ((cfg & `IDPC_PWRDN_SET) != `IDPC_PWRDN_SET);

	// The idle instruction samples the control bits as they stand;
	// a refused idle leaves every domain as it was
	always_comb begin
		next_cfg = cfg;
		next_mask = mask;
		next_req = DOM_IDLE_REQ;
		next_unit = UNIT_IDLE;
		next_err = 1'b0;
		if (wr_commit && wr_sel == RS_CFG) next_cfg = wr_merge(cfg, w_data, w_strb, `IDPC_CFG_WMASK);
		if (wr_commit && wr_sel == RS_MASK) next_mask = wr_merge(mask, w_data, w_strb, `IDPC_MASK_WMASK);
		if (WAKE_REQ) begin
			next_req = '0;
			next_unit = '0;
		end
		if (IDLE_EXEC) begin
			if (idle_bad) begin
				next_err = 1'b1;
			end else begin
				next_req = cfg[`IDPC_NDOM-1:0];
				next_req[`IDPC_B_CLK] = cfg[`IDPC_B_CLK] && cfg[`IDPC_B_CLKX];
				// Group clear wakes all, group set follows the mask
				next_unit = cfg[`IDPC_B_UGROUP] ? mask[`IDPC_NUNIT-1:0] : '0;
			end
		end
	end

	// Control registers
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			cfg <= `IDPC_CFG_RST;
			mask <= `IDPC_MASK_RST;
			DOM_IDLE_REQ <= '0;
			UNIT_IDLE <= '0;
			BUS_ERR_IRQ <= 1'b0;
		end else begin
			cfg <= next_cfg;
			mask <= next_mask;
			DOM_IDLE_REQ <= next_req;
			UNIT_IDLE <= next_unit;
			BUS_ERR_IRQ <= next_err;
		end
	end

	// One status sequencer per domain, status bit index = control bit index
	for (genvar i = 0; i < `IDPC_NDOM; i++) begin : g_dom
		idpc_dom u_dom (
			.clk(REF_CLK),
			.rst_n(rst_n),
			.idle_req(DOM_IDLE_REQ[i]),
			.stop_ack(DOM_STOP_ACK[i]),
			.idle_stat(dom_stat[i])
		);
	end

	// ----------------------------------------
	// Bus read path
	// ----------------------------------------
	logic next_arready, next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	// One read at a time; data captured at the address edge
	always_comb begin
		next_rvalid = S_AXI_RVALID;
		next_rdata = S_AXI_RDATA;
		next_rresp = S_AXI_RRESP;
		if (S_AXI_RVALID && S_AXI_RREADY) next_rvalid = 1'b0;
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			next_rvalid = 1'b1;
			next_rresp = `IDPC_RESP_OKAY;
			case (reg_sel(S_AXI_ARADDR))
				RS_CFG: next_rdata = {16'h0000, cfg};
				RS_STAT: next_rdata = {23'h000000, dom_stat};
				RS_MASK: next_rdata = {16'h0000, mask};
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = `IDPC_RESP_SLVERR;
				end
			endcase
		end
		next_arready = !next_rvalid;
	end

	// Read path registers
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= `IDPC_RESP_OKAY;
		end else begin
			S_AXI_ARREADY <= next_arready;
			S_AXI_RVALID <= next_rvalid;
			S_AXI_RDATA <= next_rdata;
			S_AXI_RRESP <= next_rresp;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!rst_n);

	a_ext_mem_if_idle_follow: assert property (
		IDLE_EXEC && !idle_bad |=> DOM_IDLE_REQ[`IDPC_B_EXT_MEM_IF] == $past(cfg[`IDPC_B_EXT_MEM_IF]))
		else $error("memory interface request does not follow its bit");
	a_ioport_idle_follow: assert property (
		IDLE_EXEC && !idle_bad |=> DOM_IDLE_REQ[`IDPC_B_IOPORT] == $past(cfg[`IDPC_B_IOPORT]))
		else $error("I/O-space port request does not follow its bit");
	a_clkgen_stop_pair: assert property (
		IDLE_EXEC && !idle_bad |=> DOM_IDLE_REQ[`IDPC_B_CLK] == ($past(cfg[`IDPC_B_CLK]) && $past(cfg[`IDPC_B_CLKX])))
		else $error("clock generator stopped without both bits");
	a_clkgen_mixed_err: assert property (
		IDLE_EXEC && !WAKE_REQ && cfg[`IDPC_B_CLK] && !cfg[`IDPC_B_CLKX] |=> BUS_ERR_IRQ && $stable(DOM_IDLE_REQ))
		else $error("mixed clock idle bits did not raise bus error");
	a_pwrdn_set_err: assert property (
		IDLE_EXEC && cfg[`IDPC_B_CLK] && (cfg & `IDPC_PWRDN_SET) != `IDPC_PWRDN_SET
		|=> BUS_ERR_IRQ ##1 (!BUS_ERR_IRQ || $past(IDLE_EXEC)))
		else $error("incomplete power-down did not raise bus error");
	a_err_only_idle: assert property (
		!IDLE_EXEC |=> !BUS_ERR_IRQ)
		else $error("bus error without idle instruction");
	a_group_wake_all: assert property (
		IDLE_EXEC && !idle_bad && !cfg[`IDPC_B_UGROUP] |=> UNIT_IDLE == '0)
		else $error("group clear did not wake all peripherals");
	a_group_mask_sel: assert property (
		IDLE_EXEC && !idle_bad && cfg[`IDPC_B_UGROUP] |=> UNIT_IDLE == $past(mask[`IDPC_NUNIT-1:0]))
		else $error("peripherals do not follow the mask");
	a_instr_cache_idle_follow: assert property (
		IDLE_EXEC && !idle_bad |=> DOM_IDLE_REQ[`IDPC_B_INSTR_CACHE] == $past(cfg[`IDPC_B_INSTR_CACHE]))
		else $error("cache request does not follow its bit");
	a_munit_idle_follow: assert property (
		IDLE_EXEC && !idle_bad |=> DOM_IDLE_REQ[`IDPC_B_MUNIT] == $past(cfg[`IDPC_B_MUNIT]))
		else $error("master unit request does not follow its bit");
	a_core_idle_follow: assert property (
		IDLE_EXEC && !idle_bad |=> DOM_IDLE_REQ[`IDPC_B_CORE] == $past(cfg[`IDPC_B_CORE]))
		else $error("core request does not follow its bit");
	a_fport_idle_follow: assert property (
		IDLE_EXEC && !idle_bad |=> DOM_IDLE_REQ[`IDPC_B_FPORT] == $past(cfg[`IDPC_B_FPORT]))
		else $error("fetch port request does not follow its bit");
	a_master_port_idle_follow: assert property (
		IDLE_EXEC && !idle_bad |=> DOM_IDLE_REQ[`IDPC_B_MASTER_PORT] == $past(cfg[`IDPC_B_MASTER_PORT]))
		else $error("master port request does not follow its bit");
	a_stat_read_word: assert property (
		S_AXI_ARVALID && S_AXI_ARREADY && reg_sel(S_AXI_ARADDR) == RS_STAT
		|=> S_AXI_RVALID && S_AXI_RDATA == {23'h000000, $past(dom_stat)})
		else $error("status read does not show domain state");
endmodule : idpc_top

// file: bench/idle_domain_power_control_tb.sv
`timescale 1ns/1ns
`include "idpc_params.svh"
module idle_domain_power_control_tb
	import idpc_pkg::*;
;
	// ----------------------------------------
	// Signals and model state
	// ----------------------------------------
	logic REF_CLK = 1'b0;
	logic RST_B = 1'b0;
	logic [`IDPC_AW-1:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
	logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
	logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, BUS_ERR_IRQ;
	logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB = 4'hF;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic IDLE_EXEC = 1'b0, WAKE_REQ = 1'b0;
	logic [`IDPC_NDOM-1:0] DOM_IDLE_REQ, DOM_STOP_ACK = '0;
	logic [`IDPC_NUNIT-1:0] UNIT_IDLE;
	logic [31:0] seed = 32'hDEF0F88B;
	localparam logic [19:0] CFG_A = {`IDPC_CFG_IDX, 2'h0};
	localparam logic [19:0] STAT_A = {`IDPC_STAT_IDX, 2'h0};
	localparam logic [19:0] MASK_A = {`IDPC_MASK_IDX, 2'h0};
	int errors = 0, total_checks = 0;
	int m_cfg = 0, m_mask = 0, m_req = 0, m_unit = 0;
	int cfg_list[$] = '{32'h0001, 32'h0010, 32'h0200, 32'h03FF, 32'h0008};
	idpc_top dut_u (.REF_CLK(REF_CLK), .RST_B(RST_B), .S_AXI_AWADDR(S_AXI_AWADDR),
		.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
		.S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
		.S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
		.S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
		.S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
		.S_AXI_RREADY(S_AXI_RREADY), .IDLE_EXEC(IDLE_EXEC), .WAKE_REQ(WAKE_REQ),
		.DOM_IDLE_REQ(DOM_IDLE_REQ), .DOM_STOP_ACK(DOM_STOP_ACK), .UNIT_IDLE(UNIT_IDLE),
		.BUS_ERR_IRQ(BUS_ERR_IRQ));
	// Free-running system clock
	initial begin
		forever #5 REF_CLK = ~REF_CLK;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic print_verdict;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Every wait is bounded, a hang ends the run as a failure
	task automatic guard(inout int n);
		n++;
		if (n > 50) begin
			errors++;
			print_verdict();
		end
	endtask : guard
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Write channels released one by one as each is taken
	task automatic axi_write(input logic [19:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		bit aw, w;
		n = 0;
		aw = 0;
		w = 0;
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		forever begin
			@(posedge REF_CLK);
			guard(n);
			if (!aw && S_AXI_AWREADY === 1'b1) begin
				aw = 1;
				S_AXI_AWVALID <= 1'b0;
			end
			if (!w && S_AXI_WREADY === 1'b1) begin
				w = 1;
				S_AXI_WVALID <= 1'b0;
			end
			if (S_AXI_BVALID === 1'b1) begin
				r = S_AXI_BRESP;
				break;
			end
		end
		S_AXI_BREADY <= 1'b0;
		@(posedge REF_CLK);
	endtask : axi_write
	task automatic axi_read(input logic [19:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		forever begin
			@(posedge REF_CLK);
			guard(n);
			if (S_AXI_ARREADY === 1'b1) begin
				S_AXI_ARVALID <= 1'b0;
			end
			if (S_AXI_RVALID === 1'b1) begin
				d = S_AXI_RDATA;
				r = S_AXI_RRESP;
				break;
			end
		end
		S_AXI_RREADY <= 1'b0;
		@(posedge REF_CLK);
	endtask : axi_read
	// Status read compared with the model's stopped domains
	task automatic check_status;
		logic [31:0] d;
		logic [1:0] r;
		axi_read(STAT_A, d, r);
		check(r, 32'h0);
		check(d, 32'(m_req));
	endtask : check_status
	// One idle instruction; the bench then plays every stopping domain
	task automatic do_idle(input logic [31:0] c, input logic [31:0] m);
		logic [1:0] r;
		int irqs;
		bit refused;
		irqs = 0;
		axi_write(CFG_A, c, r);
		axi_write(MASK_A, m, r);
		m_cfg = c & 32'h03FF;
		m_mask = m & 32'h3FFF;
		refused = m_cfg[4] && ((m_cfg & 32'h03E7) != 32'h03E7);
		IDLE_EXEC <= 1'b1;
		@(posedge REF_CLK);
		IDLE_EXEC <= 1'b0;
		repeat (3) begin
			@(posedge REF_CLK);
			if (BUS_ERR_IRQ !== 1'b0) irqs++;
		end
		if (!refused) begin
			m_req = (m_cfg & 32'h01EF) | ((m_cfg[4] & m_cfg[9]) << 4);
			m_unit = m_cfg[3] ? m_mask : 0;
		end
		check(irqs, 32'(refused));
		check(DOM_IDLE_REQ, 32'(m_req));
		check(UNIT_IDLE, 32'(m_unit));
		DOM_STOP_ACK <= m_req[8:0];
		repeat (4) @(posedge REF_CLK);
		check_status();
	endtask : do_idle
	// Wake everything, domains report active again
	task automatic do_wake;
		WAKE_REQ <= 1'b1;
		@(posedge REF_CLK);
		WAKE_REQ <= 1'b0;
		DOM_STOP_ACK <= '0;
		m_req = 0;
		m_unit = 0;
		repeat (4) @(posedge REF_CLK);
		check(DOM_IDLE_REQ, 32'h0);
		check(UNIT_IDLE, 32'h0);
		check_status();
	endtask : do_wake
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] d, c, v;
		logic [1:0] r;
		repeat (20) @(posedge REF_CLK);
		RST_B <= 1'b1;
		repeat (4) @(posedge REF_CLK);
		// Reset values, reserved bits and refused addresses
		axi_read(CFG_A, d, r);
		check(d, 32'h0);
		axi_read(MASK_A, d, r);
		check(d, 32'h0);
		check_status();
		axi_write(CFG_A, 32'hFFFF_FFFF, r);
		axi_read(CFG_A, d, r);
		check(d, 32'h03FF);
		// Byte lanes: upper lane alone, then lower lane alone
		S_AXI_WSTRB <= 4'h2;
		axi_write(CFG_A, 32'h0, r);
		axi_read(CFG_A, d, r);
		check(d, 32'h00FF);
		S_AXI_WSTRB <= 4'h1;
		axi_write(CFG_A, 32'h0, r);
		axi_read(CFG_A, d, r);
		check(d, 32'h0);
		S_AXI_WSTRB <= 4'hF;
		axi_write(MASK_A, 32'hFFFF_FFFF, r);
		axi_read(MASK_A, d, r);
		check(d, 32'h3FFF);
		axi_write(STAT_A, 32'h01FF, r);
		check(r, 32'h0);
		check_status();
		axi_read(20'h00004, d, r);
		check(r, 32'h2);
		check(d, 32'h0);
		axi_write(20'h00004, 32'h1, r);
		check(r, 32'h2);
		// Directed cases, then each power-down bit left clear in turn
		for (int b = 0; b < 10; b++) begin
			if (b != 3 && b != 4) cfg_list.push_back(32'h03FF & ~(32'h1 << b));
		end
		foreach (cfg_list[i]) begin
			do_idle(cfg_list[i], 32'h2A5C);
			do_idle(32'h0, 32'h3FFF);
			do_wake();
		end
		// Reset in mid-run with every domain stopped drops all requests
		do_idle(32'h03FF, 32'h3FFF);
		RST_B <= 1'b0;
		DOM_STOP_ACK <= '0;
		repeat (3) @(posedge REF_CLK);
		RST_B <= 1'b1;
		m_req = 0;
		m_unit = 0;
		repeat (4) @(posedge REF_CLK);
		check(DOM_IDLE_REQ, 32'h0);
		check(UNIT_IDLE, 32'h0);
		axi_read(CFG_A, d, r);
		check(d, 32'h0);
		axi_read(MASK_A, d, r);
		check(d, 32'h0);
		check_status();
		// Random sequences, wake only now and then
		repeat (40) begin
			c = rnd() & 32'hFFFF;
			v = rnd();
			if (c[4] && v[0]) c = c | 32'h03E7;
			do_idle(c, rnd() & 32'hFFFF);
			if (v[1]) do_wake();
		end
		print_verdict();
	end
endmodule : idle_domain_power_control_tb
